// ### hw/tmc_pkg.sv
// Shared constants and types for the timer module common core.
package tmc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte registers on the plain register port)
  // ----------------------------------------------------------------
  localparam int unsigned     ADDR_W        = 4;
  localparam int unsigned     DATA_W        = 8;
  localparam logic [3:0]      REG_CTRL0     = 4'h0;
  localparam logic [3:0]      REG_CTRL1     = 4'h1;
  localparam logic [3:0]      REG_CNT_LO    = 4'h2;
  localparam logic [3:0]      REG_CNT_HI    = 4'h3;
  localparam logic [3:0]      REG_CMPA_LO   = 4'h4;
  localparam logic [3:0]      REG_CMPA_HI   = 4'h5;
  localparam logic [3:0]      REG_CMPP      = 4'h6;
  localparam logic [3:0]      REG_INT_STAT  = 4'h7;
  localparam logic [3:0]      REG_INT_MASK  = 4'h8;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]      CTRL0_MASK    = 8'hf8;
  localparam logic [7:0]      CTRL0_RST     = 8'h00;
  localparam logic [7:0]      CTRL1_RST     = 8'h00;
  localparam int unsigned     PAUSE_BIT     = 7;
  localparam int unsigned     CKSEL_LSB     = 4;
  localparam int unsigned     ON_BIT        = 3;
  localparam int unsigned     MODE_LSB      = 6;
  localparam int unsigned     IO_LSB        = 4;
  localparam int unsigned     OC_BIT        = 3;
  localparam int unsigned     POL_BIT       = 2;
  localparam int unsigned     DPX_BIT       = 1;
  localparam int unsigned     CCLR_BIT      = 0;
  localparam int unsigned     INT_A_BIT     = 0;
  localparam int unsigned     INT_P_BIT     = 1;
  localparam logic [1:0]      INT_RST       = 2'h0;

  // ----------------------------------------------------------------
  // Clock source codes and prescaler masks
  // ----------------------------------------------------------------
  localparam logic [2:0]      CK_SYS_DIV4   = 3'h0;
  localparam logic [2:0]      CK_SYS        = 3'h1;
  localparam logic [2:0]      CK_HI_DIV16   = 3'h2;
  localparam logic [2:0]      CK_HI_DIV64   = 3'h3;
  localparam logic [2:0]      CK_SUB_A      = 3'h4;
  localparam logic [2:0]      CK_SUB_B      = 3'h5;
  localparam logic [2:0]      CK_EXT_RISE   = 3'h6;
  localparam logic [2:0]      CK_EXT_FALL   = 3'h7;
  localparam logic [5:0]      DIV4_MASK     = 6'h03;
  localparam logic [5:0]      DIV16_MASK    = 6'h0f;
  localparam logic [5:0]      DIV64_MASK    = 6'h3f;

  // ----------------------------------------------------------------
  // Operating modes and pin-function codes
  // ----------------------------------------------------------------
  localparam logic [1:0]      MODE_CMP      = 2'h0;
  localparam logic [1:0]      MODE_CAP      = 2'h1;
  localparam logic [1:0]      MODE_PWM      = 2'h2;
  localparam logic [1:0]      MODE_TMR      = 2'h3;
  localparam logic [1:0]      IO_CMP_LOW    = 2'h1;
  localparam logic [1:0]      IO_CMP_HIGH   = 2'h2;
  localparam logic [1:0]      IO_CMP_TOGGLE = 2'h3;
  localparam logic [1:0]      IO_PWM_INACT  = 2'h0;
  localparam logic [1:0]      IO_PWM_ACT    = 2'h1;
  localparam logic [1:0]      IO_PWM_RUN    = 2'h2;
  localparam logic [1:0]      IO_PWM_SINGLE = 2'h3;
  localparam logic [1:0]      IO_CAP_RISE   = 2'h0;
  localparam logic [1:0]      IO_CAP_FALL   = 2'h1;
  localparam logic [1:0]      IO_CAP_BOTH   = 2'h2;

  typedef enum logic [0:0] {
    PS_WAIT,
    PS_ACTIVE
  } tmc_pulse_t;

endpackage : tmc_pkg

// ### hw/tmc_sync_edge.sv
// Two-stage synchroniser with rising and falling edge detection.
`timescale 1ns/10ps
`default_nettype none

module tmc_sync_edge (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output var  logic rise_o,
  output var  logic fall_o
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  // The first stage feeds only the second; edges are taken after it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  always_comb begin
    rise_o = sync_r & ~last_r;
    fall_o = ~sync_r & last_r;
  end

endmodule : tmc_sync_edge

`default_nettype wire

// ### hw/tmc_timer_core.sv
// Standard timer core: counter, two comparators, pins, buffered byte access.
// Notes on behaviour
// R1: Free-running up-counter compared with comparators; match interrupts, may clear, may move pin.
// R2: Separate interrupt sources for comparator A and comparator P matches.
// R3: Three-bit clock select picks system, high-clock ratios, subsidiary or external clock.
// R4: External clock counts on the rising or falling edge chosen by clock select.
// R5: In single pulse mode the external clock pin triggers the pulse.
// R6: Capture input reacts on rising, falling or both edges per pin-function field.
// R7: Periodic variant also captures on its external clock pin in capture mode.
// R8: Inverted output pin always carries the inverse of the true output.
// R9: Compare output mode drives pins low, high or toggles them on match.
// R10: PWM waveform appears on the same true and inverted output pins.
// R11: Software selects timer function in pin-sharing registers before using pins.
// R12: Counter and compare high bytes direct; low bytes through one shared buffer.
// R13: Low-byte compare write fills buffer; high-byte write stores both bytes together.
// R14: High-byte read returns high byte and copies low byte into the buffer.
// R15: Software writes low before high and reads high before low.
// R16: One edge-aligned PWM channel, duty or period adjustable, plus single pulse.
// R17: Sixteen-bit counter; comparator A uses all bits, comparator P upper eight.
// R18: Counter clears when switched on, and on overflow or selected compare match.
// R19: External clock and capture inputs are synchronised before edge detection.
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none

module tmc_timer_core #(
  parameter int unsigned CNT_W        = 16,
  parameter int unsigned CMPP_W       = 8,
  parameter bit          PERIODIC_CAP = 1'b0
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic [tmc_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [tmc_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                       we_i,
  input  wire logic                       re_i,
  output var  logic [tmc_pkg::DATA_W-1:0] rdata_o,
  input  wire logic                       sub_clk_tick_i,
  input  wire logic                       std_timer_ext_clock_in_i,
  input  wire logic                       std_timer_capture_in_i,
  output var  logic                       std_timer_out_true_o,
  output var  logic                       std_timer_out_inverted_o,
  output var  logic                       irq_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Byte access and the upper-byte comparator assume exactly this split.
  if (CNT_W != 16 || CMPP_W != 8) begin : g_bad_width
    $error("tmc_timer_core supports only a 16-bit counter and 8-bit P comparator");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]          ctrl0_r, ctrl0_nxt;
  logic [7:0]          ctrl1_r, ctrl1_nxt;
  logic [CNT_W-1:0]    cnt_r, cnt_nxt;
  logic [CNT_W-1:0]    compare_a_value_r, compare_a_value_nxt;
  logic [CMPP_W-1:0]   compare_p_value_r, compare_p_value_nxt;
  logic [7:0]          hold_r, hold_nxt;
  logic [5:0]          presc_r, presc_nxt;
  logic [1:0]          stat_r, stat_nxt;
  logic [1:0]          mask_r, mask_nxt;
  logic                out_r, out_nxt;
  tmc_pkg::tmc_pulse_t pulse_r, pulse_nxt;
  logic [7:0]          rdata_nxt;
  logic                irq_nxt;
  logic                true_r;
  logic                inv_r;

  logic                ext_rise;
  logic                ext_fall;
  logic                cap_rise;
  logic                cap_fall;
  logic                on_w, pause_w, oc_w, pol_w, dpx_w, cclr_w;
  logic [2:0]          cksel_w;
  logic [1:0]          mode_w, io_w;
  logic                tick, tick_ok, match_a, match_p, clr_cnt, cap_evt;
  logic                on_rise, pwm_act;
  logic [1:0]          stat_clr;

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  tmc_sync_edge u_ext_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (std_timer_ext_clock_in_i),
    .rise_o  (ext_rise),
    .fall_o  (ext_fall)
  ); // R19

  tmc_sync_edge u_cap_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (std_timer_capture_in_i),
    .rise_o  (cap_rise),
    .fall_o  (cap_fall)
  ); // R19

  // ----------------------------------------------------------------
  // Counter, comparators and capture
  // ----------------------------------------------------------------
  always_comb begin
    pause_w  = ctrl0_r[tmc_pkg::PAUSE_BIT];
    cksel_w  = ctrl0_r[tmc_pkg::CKSEL_LSB +: 3];
    on_w     = ctrl0_r[tmc_pkg::ON_BIT];
    mode_w   = ctrl1_r[tmc_pkg::MODE_LSB +: 2];
    io_w     = ctrl1_r[tmc_pkg::IO_LSB +: 2];
    oc_w     = ctrl1_r[tmc_pkg::OC_BIT];
    pol_w    = ctrl1_r[tmc_pkg::POL_BIT];
    dpx_w    = ctrl1_r[tmc_pkg::DPX_BIT];
    cclr_w   = ctrl1_r[tmc_pkg::CCLR_BIT];
    presc_nxt = presc_r + 6'h01;
    // The high internal clock is taken as the module clock itself.
    case (cksel_w)
      tmc_pkg::CK_SYS_DIV4: tick = (presc_r & tmc_pkg::DIV4_MASK) == tmc_pkg::DIV4_MASK;  // R3
      tmc_pkg::CK_SYS:      tick = 1'b1;                                                // R3
      tmc_pkg::CK_HI_DIV16: tick = (presc_r & tmc_pkg::DIV16_MASK) == tmc_pkg::DIV16_MASK;
      tmc_pkg::CK_HI_DIV64: tick = (presc_r & tmc_pkg::DIV64_MASK) == tmc_pkg::DIV64_MASK;
      tmc_pkg::CK_SUB_A,
      tmc_pkg::CK_SUB_B:    tick = sub_clk_tick_i;                                      // R3
      tmc_pkg::CK_EXT_RISE: tick = ext_rise;                                            // R4
      tmc_pkg::CK_EXT_FALL: tick = ext_fall;                                            // R4
      default:              tick = 1'b0;
    endcase
    tick_ok = on_w && !pause_w && tick;
    // In capture mode register A holds captured values, so it does not compare.
    match_a = tick_ok && mode_w != tmc_pkg::MODE_CAP && cnt_r == compare_a_value_r;           // R17
    match_p = tick_ok && cnt_r[CNT_W-1 -: CMPP_W] == compare_p_value_r && cnt_r[7:0] == 8'h00; // R17
    // PWM mode fixes the clearing comparator by the duty/period select.
    if (mode_w == tmc_pkg::MODE_PWM ? dpx_w : cclr_w) begin
      clr_cnt = match_a;                                                            // R18
    end else begin
      // A zero P value would pin the counter at zero, so it means run to overflow.
      clr_cnt = match_p && compare_p_value_r != '0;                                            // R18
    end
    case (io_w)
      tmc_pkg::IO_CAP_RISE: cap_evt = cap_rise;                                     // R6
      tmc_pkg::IO_CAP_FALL: cap_evt = cap_fall;                                     // R6
      tmc_pkg::IO_CAP_BOTH: cap_evt = cap_rise | cap_fall;                          // R6
      default:              cap_evt = 1'b0;
    endcase
    cap_evt = on_w && mode_w == tmc_pkg::MODE_CAP && (cap_evt || (PERIODIC_CAP && ext_rise)); // R7
    on_rise = we_i && addr_i == tmc_pkg::REG_CTRL0 && wdata_i[tmc_pkg::ON_BIT] && !on_w;
    if (on_rise) begin
      cnt_nxt = '0;                                                                 // R18
    end else if (tick_ok) begin
      cnt_nxt = clr_cnt ? '0 : cnt_r + 16'h0001;                                    // R1
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  // ----------------------------------------------------------------
  // Output pin state machine
  // ----------------------------------------------------------------
  always_comb begin
    out_nxt   = out_r;
    pulse_nxt = pulse_r;
    pwm_act   = dpx_w ? (cnt_r[CNT_W-1 -: CMPP_W] < compare_p_value_r) : (cnt_r < compare_a_value_r);    // R16
    if (on_rise) begin
      out_nxt   = oc_w;
      pulse_nxt = tmc_pkg::PS_WAIT;
    end else if (on_w) begin
      case (mode_w)
        tmc_pkg::MODE_CMP: begin
          if (match_a) begin
            case (io_w)
              tmc_pkg::IO_CMP_LOW:    out_nxt = 1'b0;                               // R9
              tmc_pkg::IO_CMP_HIGH:   out_nxt = 1'b1;                               // R9
              tmc_pkg::IO_CMP_TOGGLE: out_nxt = ~out_r;                             // R9
              default:                out_nxt = out_r;
            endcase
          end
        end
        tmc_pkg::MODE_PWM: begin
          case (io_w)
            tmc_pkg::IO_PWM_INACT: out_nxt = 1'b0;
            tmc_pkg::IO_PWM_ACT:   out_nxt = 1'b1;
            tmc_pkg::IO_PWM_RUN:   out_nxt = pwm_act;                               // R10
            default: begin
              if (pulse_r == tmc_pkg::PS_WAIT && ext_rise) begin
                out_nxt   = 1'b1;                                                   // R5
                pulse_nxt = tmc_pkg::PS_ACTIVE;
              end else if (pulse_r == tmc_pkg::PS_ACTIVE && match_a) begin
                out_nxt   = 1'b0;                                                   // R16
                pulse_nxt = tmc_pkg::PS_WAIT;
              end
            end
          endcase
        end
        default: out_nxt = out_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register port, byte buffer and interrupts
  // ----------------------------------------------------------------
  always_comb begin
    ctrl0_nxt = ctrl0_r;
    ctrl1_nxt = ctrl1_r;
    compare_a_value_nxt  = compare_a_value_r;
    compare_p_value_nxt  = compare_p_value_r;
    hold_nxt  = hold_r;
    mask_nxt  = mask_r;
    stat_clr  = 2'h0;
    rdata_nxt = 8'h00;
    if (we_i) begin
      case (addr_i)
        tmc_pkg::REG_CTRL0:    ctrl0_nxt = wdata_i & tmc_pkg::CTRL0_MASK;
        tmc_pkg::REG_CTRL1:    ctrl1_nxt = wdata_i;
        tmc_pkg::REG_CMPA_LO:  hold_nxt  = wdata_i;                                 // R13
        tmc_pkg::REG_CMPA_HI:  compare_a_value_nxt  = {wdata_i, hold_r};                       // R13
        tmc_pkg::REG_CMPP:     compare_p_value_nxt  = wdata_i;
        tmc_pkg::REG_INT_STAT: stat_clr  = wdata_i[1:0];
        tmc_pkg::REG_INT_MASK: mask_nxt  = wdata_i[1:0];
        default:               ctrl0_nxt = ctrl0_r;
      endcase
    end
    if (re_i) begin
      case (addr_i)
        tmc_pkg::REG_CTRL0:    rdata_nxt = ctrl0_r;
        tmc_pkg::REG_CTRL1:    rdata_nxt = ctrl1_r;
        tmc_pkg::REG_CNT_LO,
        tmc_pkg::REG_CMPA_LO:  rdata_nxt = hold_r;                                  // R12
        tmc_pkg::REG_CNT_HI: begin
          rdata_nxt = cnt_r[15:8];                                                  // R14
          hold_nxt  = cnt_r[7:0];                                                   // R14
        end
        tmc_pkg::REG_CMPA_HI: begin
          rdata_nxt = compare_a_value_r[15:8];                                                 // R14
          hold_nxt  = compare_a_value_r[7:0];                                                  // R14
        end
        tmc_pkg::REG_CMPP:     rdata_nxt = compare_p_value_r;
        tmc_pkg::REG_INT_STAT: rdata_nxt = {6'h00, stat_r};
        tmc_pkg::REG_INT_MASK: rdata_nxt = {6'h00, mask_r};
        default:               rdata_nxt = 8'h00;
      endcase
    end
    // A capture overrides a software write to register A in the same cycle.
    if (cap_evt) begin
      compare_a_value_nxt = cnt_r;                                                             // R6
    end
    // Hardware events win over a write-one clear in the same cycle.
    stat_nxt = stat_r & ~stat_clr;
    stat_nxt[tmc_pkg::INT_A_BIT] = stat_nxt[tmc_pkg::INT_A_BIT] | match_a | cap_evt; // R2
    stat_nxt[tmc_pkg::INT_P_BIT] = stat_nxt[tmc_pkg::INT_P_BIT] | match_p;           // R2
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl0_r <= tmc_pkg::CTRL0_RST;
      ctrl1_r <= tmc_pkg::CTRL1_RST;
      cnt_r   <= '0;
      compare_a_value_r  <= '0;
      compare_p_value_r  <= '0;
      hold_r  <= 8'h00;
      presc_r <= 6'h00;
      stat_r  <= tmc_pkg::INT_RST;
      mask_r  <= tmc_pkg::INT_RST;
      out_r   <= 1'b0;
      pulse_r <= tmc_pkg::PS_WAIT;
      rdata_o <= 8'h00;
      irq_o   <= 1'b0;
      true_r  <= 1'b0;
      inv_r   <= 1'b1;
    end else begin
      ctrl0_r <= ctrl0_nxt;
      ctrl1_r <= ctrl1_nxt;
      cnt_r   <= cnt_nxt;
      compare_a_value_r  <= compare_a_value_nxt;
      compare_p_value_r  <= compare_p_value_nxt;
      hold_r  <= hold_nxt;
      presc_r <= presc_nxt;
      stat_r  <= stat_nxt;
      mask_r  <= mask_nxt;
      out_r   <= out_nxt;
      pulse_r <= pulse_nxt;
      rdata_o <= rdata_nxt;
      irq_o   <= irq_nxt;
      true_r  <= out_nxt ^ ctrl1_nxt[tmc_pkg::POL_BIT];                             // R10
      inv_r   <= ~(out_nxt ^ ctrl1_nxt[tmc_pkg::POL_BIT]);                          // R8
    end
  end

  always_comb begin
    std_timer_out_true_o     = true_r;
    std_timer_out_inverted_o = inv_r;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_pins_inverse: assert property (std_timer_out_inverted_o == !std_timer_out_true_o) // R8
    else $error("inverted pin equals true pin");
  a_match_a_flag: assert property (match_a |=> stat_r[tmc_pkg::INT_A_BIT]) // R2
    else $error("A match did not set its flag");
  a_match_p_flag: assert property (match_p |=> stat_r[tmc_pkg::INT_P_BIT]) // R2
    else $error("P match did not set its flag");
  a_on_clears: assert property ($rose(ctrl0_r[tmc_pkg::ON_BIT]) |-> cnt_r == '0) // R18
    else $error("counter not cleared when switched on");
  a_count_step: assert property (tick_ok && !clr_cnt && !on_rise |=> cnt_r == $past(cnt_r) + 16'h0001) // R1
    else $error("counter did not advance by one");
  a_ext_edge: assert property (cksel_w == tmc_pkg::CK_EXT_FALL && !ext_fall && !on_rise |=> $stable(cnt_r)) // R4
    else $error("counter moved without a falling external edge");
  a_low_write: assert property (we_i && addr_i == tmc_pkg::REG_CMPA_LO && !cap_evt
      |=> hold_r == $past(wdata_i) && compare_a_value_r == $past(compare_a_value_r)) // R13
    else $error("low byte write leaked past the buffer");
  a_high_write: assert property (we_i && addr_i == tmc_pkg::REG_CMPA_HI && !cap_evt
      |=> compare_a_value_r == {$past(wdata_i), $past(hold_r)}) // R13
    else $error("high byte write did not join the buffer");
  a_high_read: assert property (re_i && addr_i == tmc_pkg::REG_CNT_HI
      |=> rdata_o == $past(cnt_r[15:8]) && hold_r == $past(cnt_r[7:0])) // R14
    else $error("high byte read did not latch the low byte");
  a_cmp_toggle: assert property (on_w && !on_rise && mode_w == tmc_pkg::MODE_CMP
      && io_w == tmc_pkg::IO_CMP_TOGGLE && match_a |=> out_r != $past(out_r)) // R9
    else $error("toggle on match did not toggle");
  a_capture_val: assert property (cap_evt |=> compare_a_value_r == $past(cnt_r) && stat_r[tmc_pkg::INT_A_BIT]) // R6
    else $error("capture did not store the counter");

endmodule : tmc_timer_core

`default_nettype wire

// ### testbench/tmc_pin_src.sv
// Model of the external clock and capture signal sources.
`timescale 1ns/10ps
`default_nettype none

module tmc_pin_src (
  input  wire logic clk_i,
  output var  logic ext_clk_o,
  output var  logic cap_o
);
  // The pin clock stands low between bursts so no stray edge is counted.
  initial begin
    ext_clk_o = 1'b0;
    cap_o     = 1'b0;
  end

  // Each level is held well beyond the synchroniser depth.
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge clk_i);
      ext_clk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_clk_o <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask : ext_pulses

  task automatic cap_level(input logic lvl);
    @(posedge clk_i);
    cap_o <= lvl;
    repeat (6) @(posedge clk_i);
  endtask : cap_level
endmodule : tmc_pin_src
`default_nettype wire

// ### testbench/tmc_timer_core_bench.sv
// Self-checking bench for the standard timer core.
`timescale 1ns/10ps
`default_nettype none

module tmc_timer_core_bench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  addr  = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        we    = 1'b0;
  logic        re    = 1'b0;
  logic [7:0]  rdata, lo;
  logic        ext_clk, cap, out_t, out_n, irq;
  logic        sub_tick = 1'b0;
  logic [15:0] v, e;
  logic [1:0]  io;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          seed = 901;
  int          cycles = 0;
  int          k, n;

  tmc_pin_src i_src (.clk_i(clk_i), .ext_clk_o(ext_clk), .cap_o(cap));
  tmc_timer_core #(.PERIODIC_CAP(1'b1)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr),
    .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata), .sub_clk_tick_i(sub_tick),
    .std_timer_ext_clock_in_i(ext_clk), .std_timer_capture_in_i(cap),
    .std_timer_out_true_o(out_t), .std_timer_out_inverted_o(out_n), .irq_o(irq));

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    // A fixed period of eight makes any window of 8n cycles hold exactly n ticks.
    sub_tick <= (cycles % 8) == 7;
    if (cycles == 30000) begin
      num_errors = num_errors + 1;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk_i);
    we    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk_i);
    re   <= 1'b0;
    #1 d = rdata;
  endtask : rd

  // High byte first so the low byte comes from the same snapshot.
  task automatic rd16(input logic [3:0] a, output logic [15:0] d);
    rd(a + 4'h1, d[15:8]);
    rd(a, d[7:0]);
  endtask : rd16

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_irq(input int n);
    for (int i = 0; i < n && irq !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk(16'(irq), 16'h0001);
  endtask : wait_irq

  function automatic logic cap_hit(input logic [1:0] c, input logic rise);
    return c == tmc_pkg::IO_CAP_BOTH ||
           c == (rise ? tmc_pkg::IO_CAP_RISE : tmc_pkg::IO_CAP_FALL);
  endfunction : cap_hit

  function automatic int div_of(input logic [2:0] c);
    case (c)
      tmc_pkg::CK_SYS_DIV4: return 4;
      tmc_pkg::CK_SYS:      return 1;
      tmc_pkg::CK_HI_DIV16: return 16;
      tmc_pkg::CK_HI_DIV64: return 64;
      default:              return 8;
    endcase
  endfunction : div_of

  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(tmc_pkg::REG_CTRL0, lo);
    chk(16'(lo), 16'h0000);
    chk({14'h0, out_t, out_n}, 16'h0001);
    e = 16'($random(seed));
    wr(tmc_pkg::REG_CMPA_LO, e[7:0]);
    wr(tmc_pkg::REG_CMPA_HI, e[15:8]);
    rd16(tmc_pkg::REG_CMPA_LO, v);
    chk(v, e);
    rd(4'hf, lo);
    chk(16'(lo), 16'h0000);
    // Small match value so compare A fires long before compare P clears.
    k = ($random(seed) & 31) + 2;
    wr(tmc_pkg::REG_CMPA_LO, 8'(k));
    wr(tmc_pkg::REG_CMPA_HI, 8'h00);
    wr(tmc_pkg::REG_CMPP, 8'h05);
    wr(tmc_pkg::REG_INT_MASK, 8'h03);
    wr(tmc_pkg::REG_CTRL1, 8'h30);
    wr(tmc_pkg::REG_CTRL0, 8'h18);
    wait_irq(300);
    rd(tmc_pkg::REG_INT_STAT, lo);
    chk(16'(lo), 16'h0001);
    chk({14'h0, out_t, out_n}, 16'h0002);
    wr(tmc_pkg::REG_INT_STAT, 8'h01);
    rd(tmc_pkg::REG_INT_STAT, lo);
    chk(16'(lo), 16'h0000);
    wait_irq(1500);
    rd(tmc_pkg::REG_INT_STAT, lo);
    chk(16'(lo), 16'h0002);
    wr(tmc_pkg::REG_INT_STAT, 8'h03);
    wr(tmc_pkg::REG_CTRL0, 8'h00);
    wr(tmc_pkg::REG_CTRL0, 8'h68);
    k = ($random(seed) & 15) + 1;
    i_src.ext_pulses(k);
    repeat (5) @(posedge clk_i);
    rd16(tmc_pkg::REG_CNT_LO, v);
    chk(v, 16'(k));
    wr(tmc_pkg::REG_CTRL0, 8'h00);
    wr(tmc_pkg::REG_CTRL0, 8'h78);
    rd16(tmc_pkg::REG_CNT_LO, v);
    chk(v, 16'h0000);
    i_src.ext_pulses(3);
    repeat (5) @(posedge clk_i);
    rd16(tmc_pkg::REG_CNT_LO, v);
    chk(v, 16'h0003);
    for (int i = 0; i < 3; i++) begin
      io = 2'(i);
      wr(tmc_pkg::REG_CTRL0, 8'h00);
      wr(tmc_pkg::REG_CTRL1, {tmc_pkg::MODE_CAP, io, 4'h0});
      wr(tmc_pkg::REG_CTRL0, 8'h68);
      wr(tmc_pkg::REG_INT_STAT, 8'h03);
      i_src.ext_pulses(i + 1);
      rd(tmc_pkg::REG_INT_STAT, lo);
      chk(16'(lo[0]), 16'h0001);
      wr(tmc_pkg::REG_INT_STAT, 8'h03);
      i_src.cap_level(1'b1);
      rd(tmc_pkg::REG_INT_STAT, lo);
      chk(16'(lo[0]), 16'(cap_hit(io, 1'b1)));
      wr(tmc_pkg::REG_INT_STAT, 8'h03);
      i_src.cap_level(1'b0);
      rd(tmc_pkg::REG_INT_STAT, lo);
      chk(16'(lo[0]), 16'(cap_hit(io, 1'b0)));
    end
    rd16(tmc_pkg::REG_CMPA_LO, v);
    chk(v, 16'h0003);
    for (int i = 0; i < 2; i++) begin
      wr(tmc_pkg::REG_CTRL0, 8'h00);
      wr(tmc_pkg::REG_CTRL1, {tmc_pkg::MODE_PWM, 2'(i), 4'h0});
      wr(tmc_pkg::REG_CTRL0, 8'h18);
      repeat (3) @(posedge clk_i);
      chk({14'h0, out_t, out_n}, (i == 1) ? 16'h0002 : 16'h0001);
    end
    // P value 1 gives a 257-count period, so any 257-cycle window shows k high cycles.
    k = ($random(seed) & 63) + 1;
    wr(tmc_pkg::REG_CMPA_LO, 8'(k));
    wr(tmc_pkg::REG_CMPA_HI, 8'h00);
    wr(tmc_pkg::REG_CMPP, 8'h01);
    wr(tmc_pkg::REG_CTRL0, 8'h00);
    wr(tmc_pkg::REG_CTRL1, {tmc_pkg::MODE_PWM, tmc_pkg::IO_PWM_RUN, 4'h0});
    wr(tmc_pkg::REG_CTRL0, 8'h18);
    n = 0;
    repeat (257) begin
      @(posedge clk_i);
      #1 n = n + int'(out_t);
    end
    chk(16'(n), 16'(k));
    // Single pulse counted on the trigger pin: third rising edge meets A at 2.
    wr(tmc_pkg::REG_CMPA_LO, 8'h02);
    wr(tmc_pkg::REG_CMPA_HI, 8'h00);
    wr(tmc_pkg::REG_CTRL0, 8'h00);
    wr(tmc_pkg::REG_CTRL1, {tmc_pkg::MODE_PWM, tmc_pkg::IO_PWM_SINGLE, 4'h0});
    wr(tmc_pkg::REG_CTRL0, 8'h68);
    chk({14'h0, out_t, out_n}, 16'h0001);
    i_src.ext_pulses(1);
    chk({14'h0, out_t, out_n}, 16'h0002);
    i_src.ext_pulses(2);
    chk({14'h0, out_t, out_n}, 16'h0001);
    // Clock sources 0 to 4 each run for exactly 128 cycles between switch-on and pause.
    wr(tmc_pkg::REG_CTRL1, 8'hc0);
    for (int c = 0; c < 5; c++) begin
      wr(tmc_pkg::REG_CTRL0, 8'h00);
      wr(tmc_pkg::REG_CTRL0, {1'b0, 3'(c), 4'h8});
      repeat (126) @(posedge clk_i);
      wr(tmc_pkg::REG_CTRL0, {1'b1, 3'(c), 4'h8});
      rd16(tmc_pkg::REG_CNT_LO, v);
      chk(v, 16'(128 / div_of(3'(c))));
    end
    give_verdict();
  end
endmodule : tmc_timer_core_bench
`default_nettype wire
